// ==== hw/csr_bridge_pkg.sv ====
`default_nettype none

package csr_bridge_pkg;

  // register byte addresses
  localparam logic [31:0] DATA_OFFS     = 32'h0000_0300;
  localparam logic [31:0] CMD_OFFS      = 32'h0000_0304;
  localparam logic [31:0] PRAM_WIN_OFFS = 32'h0000_0308;
  localparam logic [31:0] PRAM_CTL_OFFS = 32'h0000_030c;

  // command register fields
  localparam int BUSY_BIT  = 31;
  localparam int RNW_BIT   = 30;
  localparam int SIZE_MSB  = 18;
  localparam int SIZE_LSB  = 16;
  localparam int CADDR_MSB = 15;

  // process memory window and control fields
  localparam int LEN_MSB   = 31;
  localparam int LEN_LSB   = 16;
  localparam int START_MSB = 15;
  localparam int RUN_BIT   = 31;
  localparam int ABORT_BIT = 30;
  localparam int AVAIL_BIT = 0;

  // values after reset
  localparam logic [31:0] DATA_RST  = 32'h0000_0000;
  localparam logic [2:0]  SIZE_RST  = 3'h0;
  localparam logic [15:0] CADDR_RST = 16'h0000;
  localparam logic [15:0] LEN_RST   = 16'h0000;
  localparam logic [15:0] START_RST = 16'h0000;

  // access sizes in bytes
  localparam logic [2:0] SIZE_BYTE = 3'h1;
  localparam logic [2:0] SIZE_HALF = 3'h2;
  localparam logic [2:0] SIZE_WORD = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CSR,
    ST_PRAM
  } engine_e;

endpackage : csr_bridge_pkg

`default_nettype wire

// ==== hw/indirect_core_csr_access.sv ====
// Function
// RL1 - data register at 300h, value in low bits
// RL2 - data read gives core data when reading
// RL3 - busy bit write 1 starts core access
// RL4 - busy self-clears when core access completes
// RL5 - writing 0 to busy does nothing
// RL6 - host leaves command, data alone while busy
// RL7 - direction bit 30, 1 read, resets 0
// RL8 - size field holds 1, 2 or 4
// RL9 - core byte address in bits 15:0
// RL10 - host aligns address to access size
// RL11 - read length counts down as fetched
// RL12 - read start address counts up as fetched
// RL13 - host keeps reads inside process memory
// RL14 - host leaves window alone while running
// RL15 - running bit starts read, self-clears at end
// RL16 - host reads fifo only when data present
// RL17 - start requests ignored while already busy
//
// The AHB-Lite slave port was decided locally.
`default_nettype none

module indirect_core_csr_access (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic [31:0] hrdata,
  output var  logic        hresp,
  output var  logic        core_req,
  output var  logic        core_write,
  output var  logic [15:0] core_addr,
  output var  logic [3:0]  core_be,
  output var  logic [31:0] core_wdata,
  input  wire logic        core_ack,
  input  wire logic [31:0] core_rdata,
  output var  logic        pram_push,
  output var  logic [31:0] pram_push_data,
  input  wire logic        pram_fifo_full,
  output var  logic        pram_fifo_flush,
  input  wire logic        read_fifo_has_data
);
  // bus phase state
  logic        wr_pend_q,  wr_pend_d;
  logic [31:0] wr_addr_q,  wr_addr_d;
  logic [31:0] hrdata_q,   hrdata_d;
  logic        hready_q;
  // register and engine state
  csr_bridge_pkg::engine_e state_q, state_d;
  logic        busy_q,      busy_d;
  logic        rnw_q,       rnw_d;
  logic [2:0]  size_q,      size_d;
  logic [15:0] caddr_q,     caddr_d;
  logic [31:0] host_data_q, host_data_d;
  logic [31:0] core_data_q, core_data_d;
  logic [15:0] len_q,       len_d;
  logic [15:0] start_q,     start_d;
  logic        running_q,   running_d;
  logic        req_q,       req_d;
  logic        cwrite_q,    cwrite_d;
  logic [15:0] caddr_out_q, caddr_out_d;
  logic [3:0]  be_q,        be_d;
  logic [31:0] cwdata_q,    cwdata_d;
  logic        push_q,      push_d;
  logic [31:0] push_data_q, push_data_d;
  logic        flush_q,     flush_d;
  logic        rd_take;
  logic        wr_take;
  logic        abort_now;
  logic [4:0]  lane_shift;
  logic [3:0]  size_mask;
  logic [31:0] data_mask;
  logic [2:0]  step;
  // zero wait states, so NONSEQ and SEQ transfers are decoded alike; hsize is not checked
  function automatic logic [31:0] read_mux(input logic [31:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      csr_bridge_pkg::DATA_OFFS:
        v = rnw_q ? core_data_q : host_data_q; // see RL2
      csr_bridge_pkg::CMD_OFFS:
      begin
        v[csr_bridge_pkg::BUSY_BIT] = busy_q;
        v[csr_bridge_pkg::RNW_BIT]  = rnw_q;
        v[csr_bridge_pkg::SIZE_MSB:csr_bridge_pkg::SIZE_LSB] = size_q;
        v[csr_bridge_pkg::CADDR_MSB:0] = caddr_q;
      end
      csr_bridge_pkg::PRAM_WIN_OFFS:
      begin
        v[csr_bridge_pkg::LEN_MSB:csr_bridge_pkg::LEN_LSB] = len_q;
        v[csr_bridge_pkg::START_MSB:0] = start_q;
      end
      csr_bridge_pkg::PRAM_CTL_OFFS:
      begin
        v[csr_bridge_pkg::RUN_BIT]   = running_q;
        v[csr_bridge_pkg::AVAIL_BIT] = read_fifo_has_data;
      end
      default:
        v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux
  always_comb
  begin
    rd_take   = hsel & htrans[1] & hready & ~hwrite;
    wr_take   = hsel & htrans[1] & hready & hwrite;
    wr_pend_d = wr_take;
    wr_addr_d = wr_take ? haddr : wr_addr_q;
    hrdata_d  = rd_take ? read_mux(haddr) : hrdata_q;
  end
  always_comb
  begin
    lane_shift = {caddr_q[1:0], 3'b000};
    case (size_q) // see RL8
      csr_bridge_pkg::SIZE_BYTE:
      begin
        size_mask = 4'h1;
        data_mask = 32'h0000_00ff;
      end
      csr_bridge_pkg::SIZE_HALF:
      begin
        size_mask = 4'h3;
        data_mask = 32'h0000_ffff;
      end
      default:
      begin
        size_mask = 4'hf;
        data_mask = 32'hffff_ffff;
      end
    endcase
    // bytes left in the current dword, capped by what remains to read
    step = 3'h4 - {1'b0, start_q[1:0]};
    if (len_q < {13'h0000, step})
    begin
      step = len_q[2:0];
    end
    abort_now = wr_pend_q & (wr_addr_q == csr_bridge_pkg::PRAM_CTL_OFFS)
                & hwdata[csr_bridge_pkg::ABORT_BIT];
    state_d     = state_q;
    busy_d      = busy_q;
    rnw_d       = rnw_q;
    size_d      = size_q;
    caddr_d     = caddr_q;
    host_data_d = host_data_q;
    core_data_d = core_data_q;
    len_d       = len_q;
    start_d     = start_q;
    running_d   = running_q;
    req_d       = req_q;
    cwrite_d    = cwrite_q;
    caddr_out_d = caddr_out_q;
    be_d        = be_q;
    cwdata_d    = cwdata_q;
    push_d      = 1'b0;
    push_data_d = push_data_q;
    flush_d     = 1'b0;
    case (state_q)
      csr_bridge_pkg::ST_IDLE:
      begin
        if (busy_q)
        begin
          req_d       = 1'b1; // see RL3
          cwrite_d    = ~rnw_q; // see RL7
          caddr_out_d = caddr_q; // see RL9
          be_d        = 4'(size_mask << caddr_q[1:0]); // see RL1
          cwdata_d    = 32'((host_data_q & data_mask) << lane_shift); // see RL1
          state_d     = csr_bridge_pkg::ST_CSR;
        end
        else if (running_q)
        begin
          if (len_q == 16'h0000)
          begin
            running_d = 1'b0; // see RL15
          end
          else if (!pram_fifo_full)
          begin
            // whole aligned dword is fetched; step tells which bytes count
            req_d       = 1'b1;
            cwrite_d    = 1'b0;
            caddr_out_d = {start_q[15:2], 2'b00};
            be_d        = 4'hf;
            state_d     = csr_bridge_pkg::ST_PRAM;
          end
        end
      end
      csr_bridge_pkg::ST_CSR:
      begin
        if (core_ack)
        begin
          req_d   = 1'b0;
          busy_d  = 1'b0; // see RL4
          state_d = csr_bridge_pkg::ST_IDLE;
          if (rnw_q)
          begin
            core_data_d = (core_rdata >> lane_shift) & data_mask; // see RL1
          end
        end
      end
      csr_bridge_pkg::ST_PRAM:
      begin
        if (core_ack)
        begin
          req_d   = 1'b0;
          state_d = csr_bridge_pkg::ST_IDLE;
          // an aborted fetch still finishes on the core side but is dropped
          if (running_q && !abort_now)
          begin
            push_d      = 1'b1;
            push_data_d = core_rdata;
            len_d       = len_q - {13'h0000, step}; // see RL11
            start_d     = start_q + {13'h0000, step}; // see RL12
          end
        end
      end
      default:
      begin
        state_d = csr_bridge_pkg::ST_IDLE;
        req_d   = 1'b0;
      end
    endcase
    if (wr_pend_q)
    begin
      case (wr_addr_q)
        csr_bridge_pkg::DATA_OFFS:
        begin
          if (!busy_q)
          begin
            host_data_d = hwdata; // see RL6
          end
        end
        csr_bridge_pkg::CMD_OFFS:
        begin
          // a busy access ignores the whole write, writing 0 to busy included
          if (!busy_q) // see RL17
          begin
            busy_d  = hwdata[csr_bridge_pkg::BUSY_BIT]; // see RL5
            rnw_d   = hwdata[csr_bridge_pkg::RNW_BIT]; // see RL7
            size_d  = hwdata[csr_bridge_pkg::SIZE_MSB:csr_bridge_pkg::SIZE_LSB]; // see RL8
            caddr_d = hwdata[csr_bridge_pkg::CADDR_MSB:0]; // see RL9
          end
        end
        csr_bridge_pkg::PRAM_WIN_OFFS:
        begin
          if (!running_q) // see RL14
          begin
            len_d   = hwdata[csr_bridge_pkg::LEN_MSB:csr_bridge_pkg::LEN_LSB];
            start_d = hwdata[csr_bridge_pkg::START_MSB:0];
          end
        end
        csr_bridge_pkg::PRAM_CTL_OFFS:
        begin
          if (abort_now)
          begin
            running_d = 1'b0;
            flush_d   = 1'b1;
          end
          else if (!running_q && hwdata[csr_bridge_pkg::RUN_BIT])
          begin
            running_d = 1'b1; // see RL15
          end
        end
        default:
        begin
          host_data_d = host_data_d;
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 32'h0000_0000;
      hrdata_q    <= 32'h0000_0000;
      hready_q    <= 1'b1;
      state_q     <= csr_bridge_pkg::ST_IDLE;
      busy_q      <= 1'b0;
      rnw_q       <= 1'b0;
      size_q      <= csr_bridge_pkg::SIZE_RST;
      caddr_q     <= csr_bridge_pkg::CADDR_RST;
      host_data_q <= csr_bridge_pkg::DATA_RST;
      core_data_q <= csr_bridge_pkg::DATA_RST;
      len_q       <= csr_bridge_pkg::LEN_RST;
      start_q     <= csr_bridge_pkg::START_RST;
      running_q   <= 1'b0;
      req_q       <= 1'b0;
      cwrite_q    <= 1'b0;
      caddr_out_q <= 16'h0000;
      be_q        <= 4'h0;
      cwdata_q    <= 32'h0000_0000;
      push_q      <= 1'b0;
      push_data_q <= 32'h0000_0000;
      flush_q     <= 1'b0;
    end
    else
    begin
      wr_pend_q   <= wr_pend_d;
      wr_addr_q   <= wr_addr_d;
      hrdata_q    <= hrdata_d;
      hready_q    <= 1'b1;
      state_q     <= state_d;
      busy_q      <= busy_d;
      rnw_q       <= rnw_d;
      size_q      <= size_d;
      caddr_q     <= caddr_d;
      host_data_q <= host_data_d;
      core_data_q <= core_data_d;
      len_q       <= len_d;
      start_q     <= start_d;
      running_q   <= running_d;
      req_q       <= req_d;
      cwrite_q    <= cwrite_d;
      caddr_out_q <= caddr_out_d;
      be_q        <= be_d;
      cwdata_q    <= cwdata_d;
      push_q      <= push_d;
      push_data_q <= push_data_d;
      flush_q     <= flush_d;
    end
  end
  assign hreadyout      = hready_q;
  assign hrdata         = hrdata_q;
  assign hresp          = 1'b0;
  assign core_req       = req_q;
  assign core_write     = cwrite_q;
  assign core_addr      = caddr_out_q;
  assign core_be        = be_q;
  assign core_wdata     = cwdata_q;
  assign pram_push      = push_q;
  assign pram_push_data = push_data_q;
  assign pram_fifo_flush = flush_q;
endmodule : indirect_core_csr_access

`default_nettype wire

// ==== verif/csr_bridge_properties.sv ====
`default_nettype none
module csr_bridge_properties (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        core_req,
  input wire logic        core_write,
  input wire logic [15:0] core_addr,
  input wire logic [3:0]  core_be,
  input wire logic        core_ack,
  input wire logic        pram_push,
  input wire logic        pram_fifo_flush
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic        ap_d, ap_q, busy_d, busy_q, start, rd_take;
  logic [31:0] cmd_d, cmd_q;
  logic [3:0]  be_exp;
  always_comb
  begin
    ap_d    = hsel && htrans[1] && hready && hwrite && haddr == csr_bridge_pkg::CMD_OFFS;
    rd_take = hsel && htrans[1] && hready && !hwrite;
    start   = ap_q && hwdata[31] && !busy_q;
    cmd_d   = start ? hwdata : cmd_q;
    busy_d  = start || (busy_q && !(core_req && core_ack));
    be_exp  = (cmd_q[18:16] == 3'h1) ? 4'h1 : (cmd_q[18:16] == 3'h2) ? 4'h3 : 4'hf;
    be_exp  = be_exp << cmd_q[1:0];
  end
  // model of busy, so a second start while busy is not mistaken for a new one
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_q   <= 1'b0;
      busy_q <= 1'b0;
      cmd_q  <= 32'h0;
    end
    else
    begin
      ap_q   <= ap_d;
      busy_q <= busy_d;
      cmd_q  <= cmd_d;
    end
  end
  sequence s_issue;
    ##2 core_req && core_write == !cmd_q[30] && core_addr == cmd_q[15:0];
  endsequence
  a_start_issue: assert property (start |-> s_issue)
    else $error("core access not issued as commanded");
  a_lane_mask: assert property (core_req && busy_q |-> core_be == be_exp)
    else $error("byte lanes wrong");
  a_req_holds: assert property (core_req && !core_ack |=> core_req && $stable(core_addr))
    else $error("core request dropped early");
  a_one_access: assert property (core_req && core_ack |=> !core_req)
    else $error("core request kept after answer");
  a_push_from_ack: assert property (pram_push |-> $past(core_ack) && !$past(core_write))
    else $error("push without fetch");
  a_push_pulse: assert property (pram_push |=> !pram_push)
    else $error("push longer than one cycle");
  a_rdata_holds: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (rd_take && (haddr & ~32'hc) != 32'h300 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_flush_pulse: assert property (pram_fifo_flush |=> !pram_fifo_flush)
    else $error("flush longer than one cycle");
  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
endmodule : csr_bridge_properties
bind indirect_core_csr_access csr_bridge_properties i_csr_bridge_properties (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .hrdata, .core_req, .core_write, .core_addr, .core_be, .core_ack, .pram_push,
  .pram_fifo_flush);
`default_nettype wire

// ==== verif/core_model.sv ====
`default_nettype none
module core_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        core_req,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  lag,
  output logic             core_ack,
  output logic [31:0]      core_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // rdata toggles outside the answer so stale data never matches
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt        <= 8'h0;
      core_ack   <= 1'b0;
      core_rdata <= 32'h0;
    end
    else if (core_req && !core_ack && cnt == lag)
    begin
      cnt        <= 8'h0;
      core_ack   <= 1'b1;
      core_rdata <= {~core_addr, core_addr};
    end
    else
    begin
      cnt        <= (core_req && !core_ack) ? cnt + 8'h1 : 8'h0;
      core_ack   <= 1'b0;
      core_rdata <= ~core_rdata;
    end
  end
endmodule : core_model
`default_nettype wire

// ==== verif/tb_indirect_core_csr_access.sv ====
`default_nettype none
module tb_indirect_core_csr_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_req, core_write;
  logic        core_ack, push, flush, full, has_data, cap_w;
  logic [1:0]  htrans;
  logic [2:0]  hsize, sz;
  logic [3:0]  core_be, cap_be;
  logic [7:0]  lag;
  logic [15:0] core_addr, cap_a, a;
  logic [31:0] haddr, hwdata, hrdata, core_wdata, core_rdata, cap_wd, push_data, cap_pd;
  int          n_errors, checks, n_acks, n_push, n_flush, n0;
  assign hready = hreadyout;
  indirect_core_csr_access i_indirect_core_csr_access (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .core_req, .core_write, .core_addr, .core_be,
    .core_wdata, .core_ack, .core_rdata, .pram_push(push), .pram_push_data(push_data),
    .pram_fifo_full(full), .pram_fifo_flush(flush), .read_fifo_has_data(has_data));
  core_model i_core_model (.hclk, .hresetn, .core_req, .core_addr, .lag, .core_ack,
    .core_rdata);
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    if (core_req && core_ack)
    begin
      n_acks++;
      cap_a  = core_addr;
      cap_be = core_be;
      cap_w  = core_write;
      cap_wd = core_wdata;
    end
    n_push  += int'(push);
    n_flush += int'(flush);
    cap_pd   = push ? push_data : cap_pd;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= ad;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask : wr
  task automatic rd(input logic [31:0] ad, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    check(q, exp);
  endtask : rd
  // bounded wait for a self-clearing bit 31
  task automatic poll(input logic [31:0] ad);
    logic [31:0] q;
    q = 32'hffff_ffff;
    for (int i = 0; i < 100 && q[31] !== 1'b0; i++)
      bus(1'b0, ad, 32'h0, q);
  endtask : poll
  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, full, has_data} <= '0;
    hsize <= 3'h2;
    lag <= 8'd12;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(32'h304, 32'h0);
    rd(32'h300, 32'h0);
    rd(32'h308, 32'h0);
    check({31'h0, hresp}, 32'h0);
    wr(32'h310, 32'hffff_ffff);
    rd(32'h310, 32'h0);
    wr(32'h300, 32'h1234_5678);
    rd(32'h300, 32'h1234_5678);
    wr(32'h304, 32'h8002_0012);
    rd(32'h304, 32'h8002_0012);
    wr(32'h304, 32'h0001_0040);
    wr(32'h304, 32'hc004_0040);
    wr(32'h300, 32'h0);
    poll(32'h304);
    rd(32'h304, 32'h0002_0012);
    rd(32'h300, 32'h1234_5678);
    check({cap_w, cap_a, 11'h0, cap_be}, {1'b1, 16'h0012, 15'hc});
    check(cap_wd, 32'h5678_0000);
    for (int i = 0; i < 3; i++)
    begin
      sz = 3'h1 << i;
      a = 16'h0103 & ~(16'(sz) - 16'h1);
      lag <= 8'(i);
      wr(32'h304, {2'h3, 11'h0, sz, a});
      poll(32'h304);
      rd(32'h300, ({~a, a} >> {a[1:0], 3'h0}) & ~(32'hffff_ffff << {sz, 3'h0}));
    end
    full <= 1'b1;
    wr(32'h308, 32'h0006_1001);
    wr(32'h30c, 32'h8000_0000);
    n0 = n_acks;
    repeat (10) @(posedge hclk);
    check(n_acks, n0);
    full <= 1'b0;
    has_data <= 1'b1;
    poll(32'h30c);
    check(n_push, 2);
    check(cap_a, 16'h1004);
    check(cap_pd, 32'heffb_1004);
    rd(32'h308, 32'h0000_1007);
    rd(32'h30c, 32'h1);
    lag <= 8'd30;
    wr(32'h308, 32'h0010_1000);
    wr(32'h30c, 32'h8000_0000);
    wr(32'h30c, 32'h4000_0000);
    repeat (40) @(posedge hclk);
    check(n_flush, 1);
    check(cap_pd, 32'heffb_1004);
    check(n_push, 2);
    rd(32'h30c, 32'h1);
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    summarize();
  end
endmodule : tb_indirect_core_csr_access
`default_nettype wire
